// ---- siwr_host.sv ----
// Purpose: Host side of the two interrupt lines
// Assumes: Each line has a pull-up
// Notes: Released lines float to the pull-up level
`timescale 1ns/1ps
module siwr_host (
	// Pins
	input wire a_out,
	input wire a_oe,
	input wire b_out,
	input wire b_oe,
	// Wired lines
	output wire line_a,
	output wire line_b
);
	assign line_a = a_oe ? a_out : 1'b1;
	assign line_b = b_oe ? b_out : 1'b1;
endmodule

// ---- siwr_map.vh ----
// Purpose: Register map, field positions and reset values of the interrupt and wake router
// Assumes: Byte-wide register port inside the device
// Notes: Source bit order is shared by enable, routing and source registers
`ifndef SIWR_MAP_VH
`define SIWR_MAP_VH

`define SIWR_ADDR_SYSTEM_MODE 8'h14
`define SIWR_ADDR_IRQ_SOURCE 8'h15
`define SIWR_ADDR_WAKE_CTRL 8'h3a
`define SIWR_ADDR_IRQ_ENABLE 8'h3b
`define SIWR_ADDR_PIN_ROUTING 8'h3c

`define SIWR_RST_WAKE_CTRL 8'h00
`define SIWR_RST_IRQ_ENABLE 8'h00
`define SIWR_RST_PIN_ROUTING 8'h00

// Wake control fields
`define SIWR_WC_GATE 7
`define SIWR_WC_WAKE_HI 6
`define SIWR_WC_WAKE_LO 2
`define SIWR_WC_LEVEL 1
`define SIWR_WC_DRIVE 0

// Source positions
`define SIWR_SRC_SLEEP_CHANGE 7
`define SIWR_SRC_BUFFER 6
`define SIWR_SRC_JOLT 5
`define SIWR_SRC_MOTION_B 1
`define SIWR_SRC_SAMPLE_READY 0

// System mode fields
`define SIWR_SM_HOLD_ERR 6

`endif

// ---- siwr_pin_drive.v ----
// Purpose: Drives one interrupt pin with selectable level and drive type
// Assumes: Inputs come from the same clock domain
// Notes: Output and enable are registered so the pin never glitches
`timescale 1ns/1ps

module siwr_pin_drive (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Control
	input wire active,
	input wire active_high,
	input wire open_drain,
	// Pin
	output reg pin_out,
	output reg pin_oe
);

always @(posedge ref_clk) begin
	if (sys_rst) begin
		pin_out <= 1'b1;
		pin_oe <= 1'b1;
	end else if (open_drain) begin
		// Drive only the asserted level, release otherwise
		pin_out <= active_high;
		pin_oe <= active;
	end else begin
		pin_out <= active ? active_high : ~active_high;
		pin_oe <= 1'b1;
	end
end

endmodule

// ---- siwr_router.v ----
// Purpose: Interrupt enable, pin routing, wake selection and sample buffer gate control
// Assumes: Event flags, mode and buffer status come from logic on ref_clk
// Notes: Reads return data one cycle after the read strobe
// The enable register sits at 0x3b so that it does not collide with routing at 0x3c
// The sleep-change source is sticky until the source register is read; a new change wins
// Every other source is a live level from its functional block
// Pins are registered, so they follow a source one cycle late
`timescale 1ns/1ps
`include "siwr_map.vh"

module siwr_router (
	// Clock and reset
	input wire ref_clk,
	input wire sys_rst,
	// Register port
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata,
	// Function block events, bit 7 unused (sleep change is made here)
	input wire [7:0] block_events,
	// System mode, 1 while asleep
	input wire sleep_mode,
	input wire [1:0] system_mode_state,
	// Sample buffer
	input wire sample_strobe,
	input wire buffer_empty,
	output reg buffer_flush,
	output reg buffer_block,
	// Wake request
	output reg wake_request,
	// Interrupt pins
	output wire irq_pin_a_out,
	output wire irq_pin_a_oe,
	output wire irq_pin_b_out,
	output wire irq_pin_b_oe
);

reg [7:0] interrupt_wake_control;
reg [7:0] interrupt_enable;
reg [7:0] interrupt_pin_routing;
reg sleep_prev;
reg sleep_change_flag;
reg buffer_hold_error;
wire mode_change;
wire [7:0] raw_sources;
wire [7:0] live_sources;
wire [7:0] system_mode_reg;
wire read_source;
wire gate_set;
wire active_level;
wire drain_mode;
wire [7:0] wake_select;
wire [7:0] wake_sources;
wire gated_change;
wire free_change;
wire pin_a_active;
wire pin_b_active;

function any_routed;
	input [7:0] src;
	input [7:0] sel;
	begin
		any_routed = |(src & sel);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Register writes

always @(posedge ref_clk) begin
	if (sys_rst) begin
		interrupt_wake_control <= `SIWR_RST_WAKE_CTRL;
		interrupt_enable <= `SIWR_RST_IRQ_ENABLE;
		interrupt_pin_routing <= `SIWR_RST_PIN_ROUTING;
	end else if (reg_wr) begin
		case (reg_addr)
			`SIWR_ADDR_WAKE_CTRL: interrupt_wake_control <= reg_wdata;
			`SIWR_ADDR_IRQ_ENABLE: interrupt_enable <= reg_wdata;
			`SIWR_ADDR_PIN_ROUTING: interrupt_pin_routing <= reg_wdata;
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Control fields

assign gate_set = interrupt_wake_control[`SIWR_WC_GATE];
assign active_level = interrupt_wake_control[`SIWR_WC_LEVEL];
assign drain_mode = interrupt_wake_control[`SIWR_WC_DRIVE];
assign wake_select = {3'b000, interrupt_wake_control[`SIWR_WC_WAKE_HI:`SIWR_WC_WAKE_LO]};

////////////////////////////////////////////////////////////////////////////////
// Sources

// Only the sleep change is sticky, every other source is a live level
assign mode_change = sleep_mode ^ sleep_prev;
assign read_source = reg_rd && (reg_addr == `SIWR_ADDR_IRQ_SOURCE);

always @(posedge ref_clk) begin
	if (sys_rst) begin
		// Follow the mode in reset so that release brings no false change
		sleep_prev <= sleep_mode;
		sleep_change_flag <= 1'b0;
	end else begin
		sleep_prev <= sleep_mode;
		// Set wins over the clear by a source read
		if (mode_change && interrupt_enable[`SIWR_SRC_SLEEP_CHANGE])
			sleep_change_flag <= 1'b1;
		else if (read_source)
			sleep_change_flag <= 1'b0;
	end
end

assign raw_sources = {sleep_change_flag, block_events[6:0]};
assign live_sources = raw_sources & interrupt_enable;

////////////////////////////////////////////////////////////////////////////////
// Wake request

// Only jolt, orientation, pulse and the two motion functions can wake
assign wake_sources = {3'b000, live_sources[`SIWR_SRC_JOLT:`SIWR_SRC_MOTION_B]};

always @(posedge ref_clk) begin
	if (sys_rst)
		wake_request <= 1'b0;
	else
		wake_request <= any_routed(wake_sources, wake_select);
end

////////////////////////////////////////////////////////////////////////////////
// Buffer gate

assign gated_change = mode_change && gate_set;
assign free_change = mode_change && !gate_set;

always @(posedge ref_clk) begin
	if (sys_rst) begin
		buffer_flush <= 1'b0;
		buffer_block <= 1'b0;
		buffer_hold_error <= 1'b0;
	end else begin
		buffer_flush <= free_change;
		if (gated_change)
			buffer_block <= 1'b1;
		else if (buffer_empty)
			buffer_block <= 1'b0;
		// The hold error stays up until the host has emptied the buffer
		if (buffer_block && sample_strobe && !buffer_empty)
			buffer_hold_error <= 1'b1;
		else if (buffer_empty)
			buffer_hold_error <= 1'b0;
	end
end

assign system_mode_reg = {1'b0, buffer_hold_error, 4'h0, system_mode_state};

////////////////////////////////////////////////////////////////////////////////
// Register reads

always @(posedge ref_clk) begin
	if (sys_rst)
		reg_rdata <= 8'h00;
	else if (reg_rd) begin
		case (reg_addr)
			`SIWR_ADDR_SYSTEM_MODE: reg_rdata <= system_mode_reg;
			`SIWR_ADDR_IRQ_SOURCE: reg_rdata <= live_sources;
			`SIWR_ADDR_WAKE_CTRL: reg_rdata <= interrupt_wake_control;
			`SIWR_ADDR_IRQ_ENABLE: reg_rdata <= interrupt_enable;
			`SIWR_ADDR_PIN_ROUTING: reg_rdata <= interrupt_pin_routing;
			// Unmapped addresses read as zero
			default: reg_rdata <= 8'h00;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// Pins

// A pin is active while any enabled source routed to it is active
assign pin_a_active = any_routed(live_sources, interrupt_pin_routing);
assign pin_b_active = any_routed(live_sources, ~interrupt_pin_routing);

siwr_pin_drive u_pin_a (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.active(pin_a_active),
	.active_high(active_level),
	.open_drain(drain_mode),
	.pin_out(irq_pin_a_out),
	.pin_oe(irq_pin_a_oe)
);

siwr_pin_drive u_pin_b (
	.ref_clk(ref_clk),
	.sys_rst(sys_rst),
	.active(pin_b_active),
	.active_high(active_level),
	.open_drain(drain_mode),
	.pin_out(irq_pin_b_out),
	.pin_oe(irq_pin_b_oe)
);

endmodule

// ---- siwr_router_assertions.sv ----
// Purpose: Port checks of the router
// Assumes: Shadows follow writes on the port
// Notes: Pin checks skip the sticky source
`timescale 1ns/1ps
module siwr_chk (
	input wire ref_clk,
	input wire sys_rst,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	input wire [7:0] reg_rdata,
	input wire [7:0] block_events,
	input wire sleep_mode,
	input wire buffer_flush,
	input wire buffer_block,
	input wire buffer_empty,
	input wire wake_request,
	input wire irq_pin_a_out,
	input wire irq_pin_a_oe,
	input wire irq_pin_b_out,
	input wire irq_pin_b_oe
);
	logic [7:0] wc, en, rt;
	wire [6:0] hit = block_events[6:0] & en[6:0];
	wire act_a = |(hit & rt[6:0]);
	wire act_b = |(hit & ~rt[6:0]);
	wire wake_exp = |(block_events[5:1] & en[5:1] & wc[6:2]);
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			{wc, en, rt} <= 24'h0;
		end else if (reg_wr) begin
			case (reg_addr)
			8'h3a: wc <= reg_wdata;
			8'h3b: en <= reg_wdata;
			8'h3c: rt <= reg_wdata;
			default: ;
			endcase
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_flush_on_change: assert property (!wc[7] && $changed(sleep_mode) |=> buffer_flush)
		else $error("no flush");
	a_block_on_gate: assert property (wc[7] && $changed(sleep_mode) |=> buffer_block)
		else $error("no block");
	a_block_release: assert property (!(wc[7] && $changed(sleep_mode)) && buffer_empty |=>
		!buffer_block) else $error("block held");
	a_pin_a_pp: assert property (!en[7] && !wc[0] |=> irq_pin_a_oe &&
		irq_pin_a_out == ($past(act_a) ~^ $past(wc[1]))) else $error("pin a level");
	a_pin_b_pp: assert property (!en[7] && !wc[0] |=> irq_pin_b_oe &&
		irq_pin_b_out == ($past(act_b) ~^ $past(wc[1]))) else $error("pin b level");
	a_pin_a_od: assert property (!en[7] && wc[0] |=> irq_pin_a_oe == $past(act_a) &&
		irq_pin_a_out == $past(wc[1])) else $error("pin a drain");
	a_pin_b_od: assert property (!en[7] && wc[0] |=> irq_pin_b_oe == $past(act_b) &&
		irq_pin_b_out == $past(wc[1])) else $error("pin b drain");
	a_wake_sel: assert property (1'b1 |=>
		wake_request == $past(wake_exp)) else $error("wake");
	a_enable_read: assert property (reg_rd && reg_addr == 8'h3b |=> reg_rdata == $past(en))
		else $error("enable read");
endmodule
bind siwr_router siwr_chk u_chk (.*);

// ---- testbench.sv ----
// Purpose: Self-checking bench of the router
// Assumes: Reads answer one cycle after the strobe
// Notes: Pin timing is judged by the checker
`timescale 1ns/1ps
module testbench;
	logic ref_clk, sys_rst, reg_wr, reg_rd, sleep_mode, sample_strobe, buffer_empty;
	logic [7:0] reg_addr, reg_wdata, block_events, en, rt, wc, ev;
	logic [1:0] system_mode_state;
	wire [7:0] reg_rdata;
	wire buffer_flush, buffer_block, wake_request, line_a, line_b;
	wire irq_pin_a_out, irq_pin_a_oe, irq_pin_b_out, irq_pin_b_oe;
	logic [7:0] exp_q[$];
	logic rd_d = 0;
	int mismatches, tests_run, cyc, seed;
	siwr_router dut (.*);
	siwr_host host (.a_out(irq_pin_a_out), .a_oe(irq_pin_a_oe), .b_out(irq_pin_b_out),
		.b_oe(irq_pin_b_oe), .line_a(line_a), .line_b(line_b));
	initial begin
		ref_clk = 0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	task chk(input logic [7:0] s, e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task print_verdict;
		$display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge ref_clk);
		reg_wr <= 0;
	endtask
	task rd(input logic [7:0] a, e);
		@(posedge ref_clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		exp_q.push_back(e);
		@(posedge ref_clk);
		reg_rd <= 0;
	endtask
	always @(negedge ref_clk) begin
		if (rd_d) chk(reg_rdata, exp_q.pop_front());
		rd_d = reg_rd;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			mismatches++;
			print_verdict;
		end
	end
	initial begin
		{sys_rst, reg_wr, reg_rd, sleep_mode, sample_strobe, buffer_empty} <= 6'b100001;
		{reg_addr, reg_wdata, block_events} <= 24'h0;
		seed = $urandom(32'hb431);
		system_mode_state <= 2'($urandom);
		repeat (3) @(posedge ref_clk);
		sys_rst <= 0;
		rd(8'h3a, 0);
		rd(8'h3b, 0);
		rd(8'h3c, 0);
		rd(8'h3d, 0);
		@(negedge ref_clk) chk({6'h0, line_a, line_b}, 8'h03);
		repeat (20) begin
			en = 8'($urandom) & 8'h7f;
			rt = 8'($urandom);
			wc = 8'($urandom) & 8'h7f;
			ev = 8'($urandom);
			wr(8'h3b, en);
			wr(8'h3c, rt);
			wr(8'h3a, wc);
			block_events <= ev;
			rd(8'h3b, en);
			rd(8'h3c, rt);
			rd(8'h3a, wc);
			rd(8'h15, ev & en);
		end
		block_events <= 8'h20;
		wr(8'h3b, 8'h21);
		wr(8'h3c, 8'h20);
		wr(8'h3a, 8'h02);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) chk({6'h0, line_a, line_b}, 8'h02);
		wr(8'h3a, 8'h01);
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) chk({6'h0, line_a, line_b}, 8'h01);
		wr(8'h3b, 8'h80);
		wr(8'h3a, 8'h00);
		@(posedge ref_clk) sleep_mode <= ~sleep_mode;
		repeat (2) @(posedge ref_clk);
		rd(8'h15, 8'h80);
		rd(8'h15, 8'h00);
		wr(8'h3a, 8'h80);
		buffer_empty <= 0;
		@(posedge ref_clk) sleep_mode <= ~sleep_mode;
		repeat (3) @(posedge ref_clk);
		sample_strobe <= 1;
		@(posedge ref_clk) sample_strobe <= 0;
		rd(8'h14, {2'b01, 4'h0, system_mode_state});
		buffer_empty <= 1;
		rd(8'h14, {6'h0, system_mode_state});
		repeat (2) @(posedge ref_clk);
		if (exp_q.size() != 0) mismatches++;
		print_verdict;
	end
endmodule
